// ### rwb_pkg.sv
package rwb_pkg;

  localparam int REG_W = 16;
  localparam int ADDR_W = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_REVISION = 6'h00;
  localparam logic [5:0] IDX_FIRST_ROW = 6'h01;
  localparam logic [5:0] IDX_FIRST_COL = 6'h02;
  localparam logic [5:0] IDX_ROW_COUNT = 6'h03;
  localparam logic [5:0] IDX_COL_COUNT = 6'h04;
  localparam logic [5:0] IDX_LINE_BLANK_ALT = 6'h05;
  localparam logic [5:0] IDX_FRAME_BLANK_ALT = 6'h06;
  localparam logic [5:0] IDX_LINE_BLANK_PRI = 6'h07;
  localparam logic [5:0] IDX_FRAME_BLANK_PRI = 6'h08;
  localparam logic [5:0] IDX_CONTROL = 6'h10;
  localparam logic [5:0] IDX_INTEG_ROWS = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;

  // Value is arbitrary.
  localparam logic [15:0] REVISION_CODE = 16'h0a5c;

  // Reset values of the buffered window registers, index 8 down to 1.
  localparam logic [8:1][15:0] RST_WINDOW = {16'h0010, 16'h00ae, 16'h0020, 16'h015c,
                                             16'h0640, 16'h04b0, 16'h003c, 16'h001c};
  localparam logic [15:0] RST_CONTROL = 16'h0003;
  localparam logic [15:0] RST_INTEG_ROWS = 16'h04d0;

  localparam logic [15:0] MASK_11 = 16'h07ff;
  localparam logic [15:0] MASK_14 = 16'h3fff;
  localparam logic [15:0] MASK_15 = 16'h7fff;
  localparam logic [15:0] MASK_CONTROL = 16'h8103;
  localparam logic [15:0] MASK_INTEG_ROWS = 16'hffff;

  localparam int CTRL_LINE_SET_BIT = 0;
  localparam int CTRL_FRAME_SET_BIT = 1;
  localparam int CTRL_SHOW_BAD_BIT = 8;
  localparam int CTRL_HOLD_LOAD_BIT = 15;

  // Rows between frame start (first dark row) and the first image row.
  localparam logic [15:0] DARK_LEAD_ROWS = 16'h000a;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic frameActive;
    logic lineActive;
    logic frameStart;
    logic [10:0] rowAddr;
    logic [10:0] colAddr;
  } rwb_video_t;

  typedef struct packed {
    logic awHeld;
    logic [5:0] awIdx;
    logic wHeld;
    logic [15:0] wData;
    logic [1:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [8:1][15:0] pend;
    logic [8:1][15:0] live;
    logic [15:0] ctrl;
    logic [15:0] integRows;
    logic [15:0] rowCnt;
    logic [15:0] colCnt;
    logic masked;
    rwb_video_t vid;
  } rwb_state_t;

endpackage

// ### rwb_regs.sv
// How it works
// - First-row field picks first image row.
// - First-column field picks first image column.
// - Row-count rows read; software programs two+.
// - Context bit0 set: alternate line blanking.
// - Context bit0 clear: primary line blanking.
// - Line blanking precedes active pixels.
// - Context bit1 set: alternate frame blanking.
// - Integration rows may stretch frame blanking.
// - Bus hits window pending copy; live loads later.
// - Frame start ten rows before frame active.
// - Masked bad frame holds both actives low.
`timescale 1ns/1ps
module rwb_regs
  import rwb_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [rwb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rwb_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output rwb_pkg::rwb_video_t video
);
  import rwb_pkg::*;

  rwb_state_t s;
  rwb_state_t next_s;
  logic [15:0] lineBlank;
  logic [15:0] frameBlank;
  logic [16:0] rowLen;
  logic [16:0] frameRows;
  logic [16:0] blankedRows;
  logic lastCol;
  logic lastRow;
  logic frameStartEvt;
  logic badChange;
  logic activeRow;

  function automatic logic [15:0] fieldMask(input logic [5:0] idx);
    case (idx)
      IDX_LINE_BLANK_ALT, IDX_LINE_BLANK_PRI: fieldMask = MASK_14;
      IDX_FRAME_BLANK_ALT, IDX_FRAME_BLANK_PRI: fieldMask = MASK_15;
      default: fieldMask = MASK_11;
    endcase
  endfunction

  // Byte lanes 2 and 3 carry nothing, so only the low two strobes matter.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] data,
                                        input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] m;
    m = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    merge = m & mask;
  endfunction

  function automatic logic inWindow(input logic [5:0] idx);
    inWindow = (idx >= IDX_FIRST_ROW) && (idx <= IDX_FRAME_BLANK_PRI);
  endfunction

  assign s_axi_awready = !s.awHeld && !s.bValid;
  assign s_axi_wready = !s.wHeld && !s.bValid;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = !s.rValid;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;
  assign video = s.vid;

  // Line blanking chosen by context bit 0.
  assign lineBlank = s.ctrl[CTRL_LINE_SET_BIT] ? s.live[IDX_LINE_BLANK_ALT] : s.live[IDX_LINE_BLANK_PRI];
  // Frame blanking chosen by context bit 1.
  assign frameBlank = s.ctrl[CTRL_FRAME_SET_BIT] ? s.live[IDX_FRAME_BLANK_ALT] : s.live[IDX_FRAME_BLANK_PRI];
  assign rowLen = 17'(lineBlank) + 17'(s.live[IDX_COL_COUNT]);
  // The dark lead rows always fit inside blanking, even for tiny blanking values.
  assign blankedRows = 17'(s.live[IDX_ROW_COUNT])
                       + 17'((frameBlank > DARK_LEAD_ROWS) ? frameBlank : DARK_LEAD_ROWS);
  assign frameRows = (17'(s.integRows) + 17'h00001 > blankedRows) ? 17'(s.integRows) + 17'h00001 : blankedRows;
  // Compare with >= so a shrunken live setting cannot strand the counters.
  assign lastCol = 17'(s.colCnt) + 17'h00001 >= rowLen;
  assign lastRow = 17'(s.rowCnt) + 17'h00001 >= frameRows;
  assign frameStartEvt = lastCol && lastRow;
  // Only changes to maskable window settings spoil a frame.
  assign badChange = (s.pend[IDX_FIRST_ROW] != s.live[IDX_FIRST_ROW])
                     || (s.pend[IDX_FIRST_COL] != s.live[IDX_FIRST_COL])
                     || (s.pend[IDX_ROW_COUNT] != s.live[IDX_ROW_COUNT])
                     || (s.pend[IDX_COL_COUNT] != s.live[IDX_COL_COUNT])
                     || (s.pend[IDX_LINE_BLANK_ALT] != s.live[IDX_LINE_BLANK_ALT])
                     || (s.pend[IDX_LINE_BLANK_PRI] != s.live[IDX_LINE_BLANK_PRI]);
  // Image rows follow the ten dark lead rows.
  assign activeRow = !s.masked && (s.rowCnt >= DARK_LEAD_ROWS)
                     && (17'(s.rowCnt) < 17'(DARK_LEAD_ROWS) + 17'(s.live[IDX_ROW_COUNT]));

  always_comb begin
    logic [15:0] rdVal;
    rdVal = 16'h0000;
    next_s = s;
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.awHeld = 1'b1;
      next_s.awIdx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata[15:0];
      next_s.wStrb = s_axi_wstrb[1:0];
    end
    if (s.bValid && s_axi_bready) begin
      next_s.bValid = 1'b0;
    end
    if (s.awHeld && s.wHeld && !s.bValid) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = RESP_OKAY;
      // Window writes land in the pending copy, field bits only; control and integration rows are written directly.
      if (inWindow(s.awIdx)) begin
        next_s.pend[s.awIdx[3:0]] = merge(s.pend[s.awIdx[3:0]], s.wData, s.wStrb, fieldMask(s.awIdx));
      end else if (s.awIdx == IDX_CONTROL) begin
        next_s.ctrl = merge(s.ctrl, s.wData, s.wStrb, MASK_CONTROL);
      end else if (s.awIdx == IDX_INTEG_ROWS) begin
        next_s.integRows = merge(s.integRows, s.wData, s.wStrb, MASK_INTEG_ROWS);
      end else if (s.awIdx != IDX_REVISION && s.awIdx != IDX_STATUS) begin
        next_s.bResp = RESP_SLVERR;
      end
    end
    if (s.rValid && s_axi_rready) begin
      next_s.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rValid = 1'b1;
      next_s.rResp = RESP_OKAY;
      if (inWindow(s_axi_araddr[7:2])) begin
        rdVal = s.pend[s_axi_araddr[5:2]];
      end else begin
        case (s_axi_araddr[7:2])
          IDX_REVISION: rdVal = REVISION_CODE;
          IDX_CONTROL: rdVal = s.ctrl;
          IDX_INTEG_ROWS: rdVal = s.integRows;
          IDX_STATUS: rdVal = {13'h0000, s.masked, s.vid.lineActive, s.vid.frameActive};
          default: next_s.rResp = RESP_SLVERR;
        endcase
      end
      next_s.rData = {16'h0000, rdVal};
    end
    next_s.colCnt = lastCol ? 16'h0000 : s.colCnt + 16'h0001;
    if (lastCol) begin
      next_s.rowCnt = lastRow ? 16'h0000 : s.rowCnt + 16'h0001;
    end
    // Live copy loads when the first dark row begins.
    if (frameStartEvt && !s.ctrl[CTRL_HOLD_LOAD_BIT]) begin
      next_s.live = s.pend;
      // A masked bad frame keeps both actives low for a whole frame.
      next_s.masked = badChange && !s.ctrl[CTRL_SHOW_BAD_BIT];
    end else if (frameStartEvt) begin
      next_s.masked = 1'b0;
    end
    next_s.vid.frameStart = frameStartEvt;
    next_s.vid.frameActive = activeRow;
    // Blanking columns come first in every row.
    next_s.vid.lineActive = activeRow && (s.colCnt >= lineBlank)
                            && (17'(s.colCnt) < rowLen);
    // Addresses count from the first row and column.
    next_s.vid.rowAddr = 11'(s.live[IDX_FIRST_ROW] + s.rowCnt - DARK_LEAD_ROWS);
    next_s.vid.colAddr = 11'(s.live[IDX_FIRST_COL] + s.colCnt - lineBlank);
    if (srst) begin
      next_s = '0;
      next_s.pend = RST_WINDOW;
      next_s.live = RST_WINDOW;
      next_s.ctrl = RST_CONTROL;
      next_s.integRows = RST_INTEG_ROWS;
    end
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  first_row_a: assert property ($rose(video.frameActive) |->
      video.rowAddr == s.live[IDX_FIRST_ROW][10:0])
    else $error("First image row address wrong.");

  first_col_a: assert property ($rose(video.lineActive) |->
      video.colAddr == s.live[IDX_FIRST_COL][10:0])
    else $error("First image column address wrong.");

  row_count_a: assert property ($fell(video.frameActive) |->
      $past(video.rowAddr) == 11'(s.live[IDX_FIRST_ROW] + s.live[IDX_ROW_COUNT] - 16'h0001))
    else $error("Frame did not hold the programmed row count.");

  blank_alt_a: assert property ($rose(video.lineActive) && s.ctrl[CTRL_LINE_SET_BIT] |->
      $past(s.colCnt) == s.live[IDX_LINE_BLANK_ALT])
    else $error("Alternate line blanking not applied.");

  blank_pri_a: assert property ($rose(video.lineActive) && !s.ctrl[CTRL_LINE_SET_BIT] |->
      $past(s.colCnt) == s.live[IDX_LINE_BLANK_PRI])
    else $error("Primary line blanking not applied.");

  blank_first_a: assert property (video.lineActive |->
      $past(s.colCnt) >= $past(lineBlank))
    else $error("Pixels appeared inside line blanking.");

  frame_blank_a: assert property (frameStartEvt |->
      17'(s.rowCnt) + 17'h00001 >= 17'(s.live[IDX_ROW_COUNT]) + 17'(frameBlank))
    else $error("Frame shorter than programmed blanking.");

  stretch_a: assert property (frameStartEvt |-> s.rowCnt >= s.integRows)
    else $error("Frame not stretched for integration rows.");

  live_load_a: assert property (frameStartEvt && !s.ctrl[CTRL_HOLD_LOAD_BIT] |=>
      s.live == $past(s.pend))
    else $error("Live copy did not load at frame start.");

  live_hold_a: assert property (!frameStartEvt |=> $stable(s.live))
    else $error("Live copy changed outside frame start.");

  dark_lead_a: assert property ($rose(video.frameActive) |->
      $past(s.rowCnt) == DARK_LEAD_ROWS)
    else $error("Frame active not ten rows after frame start.");

  mask_low_a: assert property (s.masked |=> !video.frameActive && !video.lineActive)
    else $error("Masked frame showed activity.");

  field_zero_a: assert property ((s.pend[IDX_FIRST_ROW] & ~MASK_11) == 16'h0000
      && (s.pend[IDX_LINE_BLANK_ALT] & ~MASK_14) == 16'h0000
      && (s.pend[IDX_FRAME_BLANK_PRI] & ~MASK_15) == 16'h0000)
    else $error("Bits above a field were stored.");

  frame_seen_c: cover property ($rose(video.frameActive));
  masked_seen_c: cover property (frameStartEvt ##1 s.masked);
  write_done_c: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);

endmodule

// ### readout_window_blanking_regs_tb_top.sv
`timescale 1ns/1ps
module readout_window_blanking_regs_tb_top;
  import rwb_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  // Responses are always accepted at once, which AXI4-Lite allows.
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  rwb_video_t video;
  int n_errors = 0;
  int tests_run = 0;
  int c;

  always #25 clk = ~clk;

  rwb_regs dut (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .video(video));

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic guard(input int k, input int lim);
    if (k > lim) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, k, lim);
      report_and_stop();
    end
  endtask

  // Ready is looked at on the falling edge, where it has settled; the rising edge after it takes the item.
  task automatic axi_wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] st, input logic [1:0] er);
    int k;
    logic ta;
    logic tw;
    k = 0;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      k++;
      guard(k, 100);
      ta = ta || s_axi_awready === 1'b1;
      tw = tw || s_axi_wready === 1'b1;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge clk);
      k++;
      guard(k, 100);
    end while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
    int k;
    logic ta;
    k = 0;
    ta = 1'b0;
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    while (!ta) begin
      @(negedge clk);
      k++;
      guard(k, 100);
      ta = s_axi_arready === 1'b1;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    do begin
      @(negedge clk);
      k++;
      guard(k, 100);
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {16'h0000, d});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk);
  endtask

  // Counts falling edges until the chosen activity flag shows the wanted level.
  task automatic wait_vid(input int which, input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      guard(n, 40000);
    end while ((which == 0 ? video.frameActive : video.lineActive) !== lvl);
  endtask

  task automatic t_reset_values;
    axi_rd(IDX_REVISION, REVISION_CODE, RESP_OKAY);
    for (int i = 1; i <= 8; i++) begin
      axi_rd(i[5:0], RST_WINDOW[i], RESP_OKAY);
    end
    axi_rd(IDX_CONTROL, RST_CONTROL, RESP_OKAY);
    axi_rd(IDX_INTEG_ROWS, RST_INTEG_ROWS, RESP_OKAY);
    // Only dark lead rows have run so far, so no activity and no masking may show.
    axi_rd(IDX_STATUS, 16'h0000, RESP_OKAY);
    axi_wr(IDX_STATUS, 16'hffff, 4'hf, RESP_OKAY);
    axi_rd(IDX_STATUS, 16'h0000, RESP_OKAY);
  endtask

  task automatic t_fields_and_map;
    // All-ones fields stay above every software minimum.
    for (int i = 1; i <= 8; i++) begin
      axi_wr(i[5:0], 16'hffff, 4'hf, RESP_OKAY);
      axi_rd(i[5:0], i <= 4 ? MASK_11 : (i[0] ? MASK_14 : MASK_15), RESP_OKAY);
    end
    axi_wr(IDX_FIRST_ROW, 16'h1234, 4'h1, RESP_OKAY);
    axi_rd(IDX_FIRST_ROW, 16'h0734, RESP_OKAY);
    axi_wr(IDX_REVISION, 16'h5555, 4'hf, RESP_OKAY);
    axi_rd(IDX_REVISION, REVISION_CODE, RESP_OKAY);
    axi_wr(6'h09, 16'h1111, 4'hf, RESP_SLVERR);
    axi_rd(6'h09, 16'h0000, RESP_SLVERR);
  endtask

  // Pending copies now hold other values, so the first frame must still run on the reset values.
  task automatic t_video;
    wait_vid(0, 1'b1, c);
    wait_vid(1, 1'b1, c);
    chk(c, 32'h0000015c);
    chk({21'h0, video.rowAddr}, 32'h0000001c);
    chk({21'h0, video.colAddr}, 32'h0000003c);
    // The frame start pulse belongs to the first dark row only, never to an image row.
    chk({31'h0, video.frameStart}, 32'h00000000);
    wait_vid(1, 1'b0, c);
    chk(c, 32'h00000640);
    @(posedge clk);
    axi_wr(IDX_CONTROL, 16'h0002, 4'h3, RESP_OKAY);
    wait_vid(1, 1'b1, c);
    wait_vid(1, 1'b0, c);
    wait_vid(1, 1'b1, c);
    chk(c, 32'h000000ae);
    chk({21'h0, video.rowAddr}, 32'h0000001e);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_fields_and_map();
    t_video();
    report_and_stop();
  end
endmodule
